// ### hdl/lbrs_sequencer.v
// Power-up sequencer and fault supervisor for the logic rail and source-driver boost rail.
`timescale 1ns/1ps
`include "lbrs_map.vh"

// Summary of operation
// - After supply leaves lockout, wait the logic regulator start delay, then enable it.
// - Logic regulator is enabled at full target directly, no sequencer ramp.
// - Supply in lockout disables the logic regulator at once and discharges it.
// - Logic rail once enabled, or boost rail once soft-start ends, below 70% continuously over 50 ms shuts down the device.
// - Logic rail once enabled, or boost rail once soft-start ends, below 30% shuts down the device immediately, unfiltered.
// - After a fault shutdown stay disabled until power-on reset.
// - Logic regulator target picks 1.0, 1.2, 1.89 or 2.5 V by two bits.
// - Boost switching frequency picks 400, 600, 800 kHz or 1 MHz.
// - Boost target code spans 6.5 V to 9.6 V in 100 mV steps, 32 codes.
// - Boost enables 0 to 75 ms after the system reset output rises.
// - Boost reference ramps to target over 0.5 ms to 75 ms soft-start.
// - Supply in lockout disables the boost and turns on its discharge switch.
// - System reset stays low 0 to 15 ms after logic rail is up, then rises.
// - System reset stays high until power-down or a fault shutdown, through regulator dips too short to trip.

// The time base length is a parameter so that a bench may shorten the tick.
module lbrs_sequencer #(
    parameter integer TICK_CYCLES = `LBRS_TICK_CYCLES
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        supply_ok,
    input  wire        ldo_below_70,
    input  wire        ldo_below_30,
    input  wire        boost_below_70,
    input  wire        boost_below_30,
    output reg         ldo_enable,
    output reg  [1:0]  ldo_voltage_select,
    output reg         ldo_discharge,
    output reg         boost_enable,
    output reg  [1:0]  boost_freq_select,
    output reg  [4:0]  boost_voltage_code,
    output reg  [4:0]  boost_ref_code,
    output reg         output_discharge_switch,
    output reg         sys_reset_n,
    output reg         irq
);

// ----------------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------------
localparam [2:0] ST_OFF      = 3'd0;
localparam [2:0] ST_LDO_DLY  = 3'd1;
localparam [2:0] ST_RST_DLY  = 3'd2;
localparam [2:0] ST_BST_DLY  = 3'd3;
localparam [2:0] ST_BST_RAMP = 3'd4;
localparam [2:0] ST_RUN      = 3'd5;
localparam [2:0] ST_FAULT    = 3'd6;

localparam integer TICK_M1   = TICK_CYCLES - 1;
localparam integer UV_TICKS  = `LBRS_UV_TICKS;
localparam [16:0]  TICK_LAST = TICK_M1[16:0];
localparam [7:0]   UV_LIMIT  = UV_TICKS[7:0];

// Clamps a configured tick count into its documented range.
function [7:0] clamp_ticks;
    input [7:0] val;
    input [7:0] lo;
    input [7:0] hi;
    begin
        if (val < lo) begin
            clamp_ticks = lo;
        end else if (val > hi) begin
            clamp_ticks = hi;
        end else begin
            clamp_ticks = val;
        end
    end
endfunction

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg  [31:0] ctrl_reg;
reg  [31:0] cfg_reg;
reg  [`LBRS_EV_W-1:0] irq_stat_reg;
reg  [`LBRS_EV_W-1:0] irq_mask_reg;
reg  [2:0]  state_reg;
reg  [16:0] prescale_reg;
reg  [7:0]  delay_cnt_reg;
reg  [7:0]  ldo_uv_cnt_reg;
reg  [7:0]  bst_uv_cnt_reg;
reg  [12:0] ramp_acc_reg;
reg         rst_latched_reg;
reg         wr_pend_reg;
reg  [7:0]  wr_addr_reg;

wire        tick;
wire        bus_take;
wire [7:0]  ldo_dly;
wire [7:0]  rst_dly;
wire [7:0]  bst_dly;
wire [7:0]  bst_ss;
wire        ldo_checked;
wire        bst_checked;
wire        ldo_uv_trip;
wire        bst_uv_trip;
wire        ldo_sc_trip;
wire        bst_sc_trip;
wire        fault_now;
reg  [`LBRS_EV_W-1:0] event_vec;
reg  [31:0] rdata_next;
wire [12:0] ramp_sum;
wire [12:0] ramp_quot;

assign tick     = (prescale_reg == TICK_LAST);
assign bus_take = hsel & htrans[1] & hready;
assign ldo_dly  = cfg_reg[`LBRS_CFG_LDO_DLY_LSB +: 8];
assign rst_dly  = clamp_ticks(cfg_reg[`LBRS_CFG_RST_DLY_LSB +: 8], 8'd0, `LBRS_RST_DLY_MAX);
assign bst_dly  = clamp_ticks(cfg_reg[`LBRS_CFG_BST_DLY_LSB +: 8], 8'd0, `LBRS_BST_DLY_MAX);
assign bst_ss   = clamp_ticks(cfg_reg[`LBRS_CFG_BST_SS_LSB +: 8], `LBRS_BST_SS_MIN,
                              `LBRS_BST_SS_MAX);
assign ramp_sum  = ramp_acc_reg + {8'd0, boost_voltage_code};
assign ramp_quot = ramp_sum / {5'd0, bst_ss};

// ----------------------------------------------------------------------
// Fault detection
// ----------------------------------------------------------------------
// The logic rail is supervised once enabled; it has no ramp of its own.
assign ldo_checked = ldo_enable & supply_ok;
assign bst_checked = (state_reg == ST_RUN) & supply_ok;
assign ldo_sc_trip = ldo_checked & ldo_below_30;
assign bst_sc_trip = bst_checked & boost_below_30;
assign ldo_uv_trip = ldo_checked & ldo_below_70 & (ldo_uv_cnt_reg >= UV_LIMIT) & tick;
assign bst_uv_trip = bst_checked & boost_below_70 & (bst_uv_cnt_reg >= UV_LIMIT) & tick;
assign fault_now   = ldo_sc_trip | bst_sc_trip | ldo_uv_trip | bst_uv_trip;

always @* begin
    event_vec = {`LBRS_EV_W{1'b0}};
    event_vec[`LBRS_EV_LDO_UV]   = ldo_uv_trip;
    event_vec[`LBRS_EV_LDO_SC]   = ldo_sc_trip;
    event_vec[`LBRS_EV_BST_UV]   = bst_uv_trip;
    event_vec[`LBRS_EV_BST_SC]   = bst_sc_trip;
    event_vec[`LBRS_EV_LOCKOUT]  = ~supply_ok & (state_reg != ST_OFF) & (state_reg != ST_FAULT);
    event_vec[`LBRS_EV_RST_HIGH] = (state_reg == ST_RST_DLY) & tick & (delay_cnt_reg >= rst_dly);
end

// ----------------------------------------------------------------------
// Time base and undervoltage filters
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        prescale_reg   <= 17'd0;
        ldo_uv_cnt_reg <= 8'd0;
        bst_uv_cnt_reg <= 8'd0;
    end else if (clk_en) begin
        prescale_reg <= tick ? 17'd0 : prescale_reg + 17'd1;
        // A single clear sample restarts the filter, so only a continuous low trips it.
        if (!ldo_checked || !ldo_below_70) begin
            ldo_uv_cnt_reg <= 8'd0;
        end else if (tick && ldo_uv_cnt_reg < UV_LIMIT) begin
            ldo_uv_cnt_reg <= ldo_uv_cnt_reg + 8'd1;
        end
        if (!bst_checked || !boost_below_70) begin
            bst_uv_cnt_reg <= 8'd0;
        end else if (tick && bst_uv_cnt_reg < UV_LIMIT) begin
            bst_uv_cnt_reg <= bst_uv_cnt_reg + 8'd1;
        end
    end
end

// ----------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_reg               <= ST_OFF;
        delay_cnt_reg           <= 8'd0;
        ramp_acc_reg            <= 13'd0;
        rst_latched_reg         <= 1'b0;
        ldo_enable              <= 1'b0;
        ldo_discharge           <= 1'b1;
        boost_enable            <= 1'b0;
        boost_ref_code          <= 5'd0;
        output_discharge_switch <= 1'b1;
        sys_reset_n             <= 1'b0;
    end else if (clk_en) begin
        if (state_reg == ST_FAULT) begin
            // Only hresetn leaves this state; clearing the fault has no effect.
            ldo_enable              <= 1'b0;
            boost_enable            <= 1'b0;
            ldo_discharge           <= 1'b1;
            output_discharge_switch <= 1'b1;
            boost_ref_code          <= 5'd0;
            sys_reset_n             <= 1'b0;
        end else if (fault_now) begin
            state_reg               <= ST_FAULT;
            ldo_enable              <= 1'b0;
            boost_enable            <= 1'b0;
            ldo_discharge           <= 1'b1;
            output_discharge_switch <= 1'b1;
            boost_ref_code          <= 5'd0;
            sys_reset_n             <= 1'b0;
        end else if (!supply_ok) begin
            state_reg               <= ST_OFF;
            delay_cnt_reg           <= 8'd0;
            ramp_acc_reg            <= 13'd0;
            rst_latched_reg         <= 1'b0;
            ldo_enable              <= 1'b0;
            ldo_discharge           <= 1'b1;
            boost_enable            <= 1'b0;
            output_discharge_switch <= 1'b1;
            boost_ref_code          <= 5'd0;
            sys_reset_n             <= 1'b0;
        end else begin
            sys_reset_n <= rst_latched_reg;
            case (state_reg)
                ST_OFF: begin
                    state_reg     <= ST_LDO_DLY;
                    delay_cnt_reg <= 8'd0;
                end
                ST_LDO_DLY: begin
                    if (tick && delay_cnt_reg >= ldo_dly) begin
                        // Full target at once; the regulator itself limits the slew.
                        ldo_enable    <= 1'b1;
                        ldo_discharge <= 1'b0;
                        delay_cnt_reg <= 8'd0;
                        state_reg     <= ST_RST_DLY;
                    end else if (tick) begin
                        delay_cnt_reg <= delay_cnt_reg + 8'd1;
                    end
                end
                ST_RST_DLY: begin
                    if (tick && delay_cnt_reg >= rst_dly) begin
                        rst_latched_reg <= 1'b1;
                        sys_reset_n     <= 1'b1;
                        delay_cnt_reg   <= 8'd0;
                        state_reg       <= ST_BST_DLY;
                    end else if (tick) begin
                        delay_cnt_reg <= delay_cnt_reg + 8'd1;
                    end
                end
                ST_BST_DLY: begin
                    if (tick && delay_cnt_reg >= bst_dly) begin
                        boost_enable            <= 1'b1;
                        output_discharge_switch <= 1'b0;
                        delay_cnt_reg           <= 8'd0;
                        ramp_acc_reg            <= 13'd0;
                        state_reg               <= ST_BST_RAMP;
                    end else if (tick) begin
                        delay_cnt_reg <= delay_cnt_reg + 8'd1;
                    end
                end
                ST_BST_RAMP: begin
                    // Reference rises linearly: code * elapsed / soft-start ticks.
                    if (tick) begin
                        if (delay_cnt_reg + 8'd1 >= bst_ss) begin
                            boost_ref_code <= boost_voltage_code;
                            state_reg      <= ST_RUN;
                        end else begin
                            delay_cnt_reg  <= delay_cnt_reg + 8'd1;
                            ramp_acc_reg   <= ramp_sum;
                            boost_ref_code <= ramp_quot[4:0];
                        end
                    end
                end
                ST_RUN: begin
                    boost_ref_code <= boost_voltage_code;
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// Configuration outputs
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ldo_voltage_select <= 2'd0;
        boost_freq_select  <= 2'd0;
        boost_voltage_code <= 5'd0;
    end else if (clk_en) begin
        ldo_voltage_select <= ctrl_reg[`LBRS_CTRL_LDO_SEL_LSB +: 2];
        boost_freq_select  <= ctrl_reg[`LBRS_CTRL_FSW_LSB +: 2];
        boost_voltage_code <= ctrl_reg[`LBRS_CTRL_VCODE_LSB +: 5];
    end
end

// ----------------------------------------------------------------------
// AHB-Lite slave and interrupt logic
// ----------------------------------------------------------------------
always @* begin
    case (haddr[7:0])
        `LBRS_CTRL_OFS:     rdata_next = ctrl_reg;
        `LBRS_CFG_OFS:      rdata_next = cfg_reg;
        `LBRS_STATUS_OFS:   rdata_next = {24'd0, sys_reset_n, boost_enable, ldo_enable,
                                          supply_ok, 1'b0, state_reg};
        `LBRS_IRQ_STAT_OFS: rdata_next = {26'd0, irq_stat_reg};
        `LBRS_IRQ_MASK_OFS: rdata_next = {26'd0, irq_mask_reg};
        default:            rdata_next = 32'h0000_0000;
    endcase
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_reg     <= `LBRS_CTRL_RESET_VAL;
        cfg_reg      <= `LBRS_CFG_RESET_VAL;
        irq_stat_reg <= {`LBRS_EV_W{1'b0}};
        irq_mask_reg <= {`LBRS_EV_W{1'b0}};
        wr_pend_reg  <= 1'b0;
        wr_addr_reg  <= 8'h00;
        hrdata       <= 32'h0000_0000;
        hreadyout    <= 1'b1;
        hresp        <= 1'b0;
        irq          <= 1'b0;
    end else if (clk_en) begin
        wr_pend_reg <= bus_take & hwrite;
        wr_addr_reg <= haddr[7:0];
        if (bus_take && !hwrite) begin
            hrdata <= rdata_next;
        end
        if (wr_pend_reg && wr_addr_reg == `LBRS_CTRL_OFS) begin
            ctrl_reg <= hwdata;
        end
        if (wr_pend_reg && wr_addr_reg == `LBRS_CFG_OFS) begin
            cfg_reg <= hwdata;
        end
        if (wr_pend_reg && wr_addr_reg == `LBRS_IRQ_MASK_OFS) begin
            irq_mask_reg <= hwdata[`LBRS_EV_W-1:0];
        end
        // A new event wins over a write-one clear in the same cycle.
        if (wr_pend_reg && wr_addr_reg == `LBRS_IRQ_STAT_OFS) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[`LBRS_EV_W-1:0]) | event_vec;
        end else begin
            irq_stat_reg <= irq_stat_reg | event_vec;
        end
        irq <= |(irq_stat_reg & irq_mask_reg);
    end
end

endmodule // lbrs_sequencer

// ### hdl/lbrs_map.vh
// Register offsets, field positions, reset values and timing counts of the bias rail sequencer.
`ifndef LBRS_MAP_VH
`define LBRS_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LBRS_CTRL_OFS        8'h00
`define LBRS_CFG_OFS         8'h04
`define LBRS_STATUS_OFS      8'h08
`define LBRS_IRQ_STAT_OFS    8'h0C
`define LBRS_IRQ_MASK_OFS    8'h10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define LBRS_CTRL_LDO_SEL_LSB    0
`define LBRS_CTRL_FSW_LSB        2
`define LBRS_CTRL_VCODE_LSB      4
`define LBRS_CTRL_RESET_VAL      32'h0000_0000

// ----------------------------------------------------------------------
// Delay configuration register fields, each in 0.5 ms units
// ----------------------------------------------------------------------
`define LBRS_CFG_LDO_DLY_LSB     0
`define LBRS_CFG_RST_DLY_LSB     8
`define LBRS_CFG_BST_DLY_LSB     16
`define LBRS_CFG_BST_SS_LSB      24
`define LBRS_CFG_RESET_VAL       32'h0100_0000

// ----------------------------------------------------------------------
// Interrupt and status bits
// ----------------------------------------------------------------------
`define LBRS_EV_LDO_UV       0
`define LBRS_EV_LDO_SC       1
`define LBRS_EV_BST_UV       2
`define LBRS_EV_BST_SC       3
`define LBRS_EV_LOCKOUT      4
`define LBRS_EV_RST_HIGH     5
`define LBRS_EV_W            6

// ----------------------------------------------------------------------
// Timing: time base tick of 0.5 ms at 100 MHz, limits in ticks
// ----------------------------------------------------------------------
`define LBRS_CLK_MHZ         100
`define LBRS_TICK_US         500
`define LBRS_TICK_CYCLES     (`LBRS_TICK_US * `LBRS_CLK_MHZ)
`define LBRS_UV_FILTER_MS    50
`define LBRS_UV_TICKS        (`LBRS_UV_FILTER_MS * 1000 / `LBRS_TICK_US)
`define LBRS_BST_DLY_MAX     8'd150
`define LBRS_BST_SS_MIN      8'd1
`define LBRS_BST_SS_MAX      8'd150
`define LBRS_RST_DLY_MAX     8'd30

`endif

// ### testbench/lbrs_rail_model.sv
// Behavioural model of the two regulators and their level comparators.
`timescale 1ns/1ps
module lbrs_rail_model #(parameter integer RISE = 200) (
    input  wire hclk,
    input  wire ldo_enable,
    input  wire boost_enable,
    input  wire ldo_short,
    input  wire boost_short,
    input  wire ldo_dip,
    output wire ldo_below_70,
    output wire ldo_below_30,
    output wire boost_below_70,
    output wire boost_below_30
);
    integer rise_cnt = 0;
    // The boost output climbs over RISE cycles and collapses when disabled.
    always @(posedge hclk)
        rise_cnt <= !boost_enable ? 0 : (rise_cnt < RISE) ? rise_cnt + 1 : rise_cnt;
    // The logic rail follows its enable at once, since it has no ramp.
    assign ldo_below_70   = !ldo_enable || ldo_short || ldo_dip;
    assign ldo_below_30   = !ldo_enable || ldo_short;
    assign boost_below_70 = boost_short || rise_cnt < RISE;
    assign boost_below_30 = boost_short || rise_cnt < RISE / 2;
endmodule // lbrs_rail_model

// ### testbench/lbrs_chk_asserts.sv
// Port-level assertions for the bias rail sequencer.
`timescale 1ns/1ps
`include "lbrs_map.vh"
module lbrs_chk #(parameter int TICK_CYCLES = `LBRS_TICK_CYCLES) (
    input wire       hclk,
    input wire       hresetn,
    input wire       clk_en,
    input wire       supply_ok,
    input wire       ldo_below_70,
    input wire       ldo_below_30,
    input wire       boost_below_70,
    input wire       boost_below_30,
    input wire       ldo_enable,
    input wire       ldo_discharge,
    input wire       boost_enable,
    input wire [4:0] boost_voltage_code,
    input wire [4:0] boost_ref_code,
    input wire       output_discharge_switch,
    input wire       sys_reset_n
);
    reg [22:0] uv_cnt;
    reg [16:0] run_cnt;
    localparam int UV_MIN = `LBRS_UV_TICKS * TICK_CYCLES;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------
    // Unbroken undervoltage time and time spent at the boost target.
    // ------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uv_cnt  <= 23'h0;
            run_cnt <= 17'h0;
        end else if (clk_en) begin
            uv_cnt  <= !(ldo_below_70 || boost_below_70) ? 23'h0 : uv_cnt + {22'h0, ~&uv_cnt};
            run_cnt <= !(boost_enable && boost_ref_code == boost_voltage_code) ? 17'h0
                : run_cnt + {16'h0, ~&run_cnt};
        end
    end
    chk_lockout_off: assert property (clk_en && !supply_ok |=>
        !ldo_enable && !boost_enable && ldo_discharge && output_discharge_switch)
        else $error("rail left on in lockout");
    chk_ldo_short: assert property (clk_en && ldo_enable && ldo_below_30 |=>
        !ldo_enable && !boost_enable && !sys_reset_n) else $error("ldo short ignored");
    chk_boost_short: assert property (run_cnt > TICK_CYCLES && clk_en && boost_below_30
        |=> !boost_enable && !ldo_enable) else $error("boost short ignored");
    chk_fault_latch: assert property ($fell(ldo_enable) && $past(supply_ok) |->
        !ldo_enable [*8]) else $error("restart after fault");
    chk_ldo_start: assert property ($rose(ldo_enable) |->
        $past(supply_ok, 2) && $past(supply_ok)) else $error("ldo on without supply");
    chk_rst_order: assert property ($rose(sys_reset_n) |->
        ldo_enable && $past(ldo_enable) && !boost_enable) else $error("early reset release");
    chk_boost_start: assert property ($rose(boost_enable) |->
        sys_reset_n && $past(sys_reset_n)) else $error("boost before reset release");
    chk_uv_filter: assert property ($fell(ldo_enable) && $past(supply_ok) &&
        !$past(ldo_below_30) && !$past(boost_below_30) |-> uv_cnt >= UV_MIN)
        else $error("undervoltage trip too early");
    cov_ldo_on: cover property ($rose(ldo_enable));
    cov_boost_run: cover property (run_cnt == TICK_CYCLES + 1);
    cov_fault: cover property ($fell(ldo_enable) && $past(supply_ok));
endmodule // lbrs_chk
bind lbrs_sequencer lbrs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.hclk, .hresetn, .clk_en,
    .supply_ok, .ldo_below_70,
    .ldo_below_30, .boost_below_70, .boost_below_30, .ldo_enable, .ldo_discharge,
    .boost_enable, .boost_voltage_code, .boost_ref_code, .output_discharge_switch,
    .sys_reset_n);

// ### testbench/test_lcd_bias_rail_sequencer.sv
// Self-checking testbench of the bias rail sequencer with a regulator model.
`timescale 1ns/1ps
`include "lbrs_map.vh"
module test_lcd_bias_rail_sequencer;
    reg          hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    reg          supply_ok = 1'b0, ldo_short = 1'b0, boost_short = 1'b0, ldo_dip = 1'b0;
    reg          rd_dp = 1'b0;
    reg  [31:0]  haddr = 32'h0, hwdata = 32'h0, rnd = 32'h27;
    reg  [1:0]   htrans = 2'h0;
    reg  [2:0]   hsize = 3'h2;
    wire [31:0]  hrdata;
    wire         hready, hreadyout, hresp, ldo_enable, ldo_discharge, boost_enable, irq;
    wire         output_discharge_switch, sys_reset_n, ldo_below_70, ldo_below_30;
    wire         boost_below_70, boost_below_30;
    wire [1:0]   ldo_voltage_select, boost_freq_select;
    wire [4:0]   boost_voltage_code, boost_ref_code;
    wire [3:0]   mon;
    integer      err_total = 0, tests_run = 0, cyc = 0;
    logic [31:0] exp_q[$], msk_q[$];
    assign hready = hreadyout;
    assign mon = {boost_enable && boost_ref_code == boost_voltage_code, boost_enable,
                  sys_reset_n, ldo_enable};
    lbrs_sequencer #(.TICK_CYCLES(40)) dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr,
        .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .supply_ok, .ldo_below_70,
        .ldo_below_30, .boost_below_70, .boost_below_30, .ldo_enable, .ldo_voltage_select,
        .ldo_discharge, .boost_enable, .boost_freq_select, .boost_voltage_code,
        .boost_ref_code, .output_discharge_switch, .sys_reset_n, .irq);
    lbrs_rail_model #(.RISE(10)) rail_u (.hclk, .ldo_enable, .boost_enable, .ldo_short,
        .boost_short, .ldo_dip, .ldo_below_70, .ldo_below_30, .boost_below_70,
        .boost_below_30);
    initial forever #5 hclk = ~hclk;
    // ------------
    // Checking, bus access and run control.
    // ------------
    task automatic chk_pin(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // Read data is compared by the monitor against the oldest note.
    always @(posedge hclk) begin
        cyc++;
        if (rd_dp && hreadyout === 1'b1) begin
            chk_pin("hrdata", exp_q.pop_front() & msk_q[0], hrdata & msk_q[0]);
            chk_pin("hresp", 1'b0, hresp);
            msk_q.delete(0);
        end
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp  <= !wr;
        if (!wr) exp_q.push_back(d);
        if (!wr) msk_q.push_back(m);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_dp <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic wait_bit(input int b, input int n);
        while (mon[b] !== 1'b1 && n-- > 0) @(posedge hclk);
        #1;
    endtask
    initial begin
        logic [31:0] v;
        tick(20);
        @(posedge hclk) hresetn <= 1'b1;
        bus(1'b0, `LBRS_CTRL_OFS, `LBRS_CTRL_RESET_VAL, 32'hFFFFFFFF);
        bus(1'b0, `LBRS_CFG_OFS, `LBRS_CFG_RESET_VAL, 32'hFFFFFFFF);
        bus(1'b0, `LBRS_IRQ_MASK_OFS, 32'h0, 32'hFFFFFFFF);
        bus(1'b0, 8'h14, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            v = {23'h0, (i == 3) ? 5'h1F : (i == 0) ? 5'h00 : rnd[8:4], 2'(3 - i), 2'(i)};
            bus(1'b1, `LBRS_CTRL_OFS, v, 32'h0);
            bus(1'b0, `LBRS_CTRL_OFS, v, 32'h1FF);
            tick(2);
            chk_pin("ldo_voltage_select", v[1:0], ldo_voltage_select);
            chk_pin("boost_freq_select", v[3:2], boost_freq_select);
            chk_pin("boost_voltage_code", v[8:4], boost_voltage_code);
        end
        bus(1'b1, `LBRS_IRQ_MASK_OFS, 32'h33, 32'h0);
        $display("test registers done");
        @(posedge hclk) supply_ok <= 1'b1;
        wait_bit(0, 60000);
        chk_pin("ldo_enable", 1'b1, ldo_enable);
        chk_pin("ldo_discharge", 1'b0, ldo_discharge);
        chk_pin("sys_reset_n", 1'b0, sys_reset_n);
        wait_bit(1, 60000);
        tick(2);
        chk_pin("irq", 1'b1, irq);
        bus(1'b0, `LBRS_IRQ_STAT_OFS, 32'h20, 32'h20);
        bus(1'b1, `LBRS_IRQ_STAT_OFS, 32'h20, 32'h0);
        bus(1'b0, `LBRS_IRQ_STAT_OFS, 32'h0, 32'h20);
        chk_pin("irq", 1'b0, irq);
        chk_pin("boost_enable", 1'b0, boost_enable);
        wait_bit(2, 60000);
        chk_pin("boost_ref_code start", 1'b1, boost_ref_code < 5'h1F);
        wait_bit(3, 60000);
        chk_pin("boost_ref_code", 5'h1F, boost_ref_code);
        bus(1'b0, `LBRS_STATUS_OFS, 32'hF0, 32'hF0);
        @(posedge hclk) ldo_dip <= 1'b1;
        tick(1000);
        @(posedge hclk) ldo_dip <= 1'b0;
        tick(2);
        chk_pin("ldo_enable after dip", 1'b1, ldo_enable);
        chk_pin("sys_reset_n after dip", 1'b1, sys_reset_n);
        @(posedge hclk) supply_ok <= 1'b0;
        tick(2);
        chk_pin("ldo_enable", 1'b0, ldo_enable);
        chk_pin("ldo_discharge", 1'b1, ldo_discharge);
        chk_pin("boost_enable", 1'b0, boost_enable);
        chk_pin("output_discharge_switch", 1'b1, output_discharge_switch);
        chk_pin("irq", 1'b1, irq);
        $display("test power up and lockout done");
        @(posedge hclk) supply_ok <= 1'b1;
        wait_bit(0, 60000);
        @(posedge hclk) ldo_short <= 1'b1;
        tick(2);
        chk_pin("ldo_enable", 1'b0, ldo_enable);
        bus(1'b0, `LBRS_IRQ_STAT_OFS, 32'h12, 32'h12);
        @(posedge hclk) ldo_short <= 1'b0;
        @(posedge hclk) supply_ok <= 1'b0;
        @(posedge hclk) supply_ok <= 1'b1;
        tick(300);
        chk_pin("ldo_enable latched", 1'b0, ldo_enable);
        @(posedge hclk) hresetn <= 1'b0;
        tick(20);
        @(posedge hclk) hresetn <= 1'b1;
        bus(1'b1, `LBRS_CTRL_OFS, 32'h1F0, 32'h0);
        wait_bit(0, 60000);
        chk_pin("ldo_enable after reset", 1'b1, ldo_enable);
        wait_bit(3, 200000);
        tick(50);
        chk_pin("boost_enable", 1'b1, boost_enable);
        @(posedge hclk) boost_short <= 1'b1;
        tick(2);
        chk_pin("boost_enable", 1'b0, boost_enable);
        chk_pin("ldo_enable", 1'b0, ldo_enable);
        $display("test faults done");
        @(posedge hclk) {hresetn, boost_short} <= 2'b00;
        tick(20);
        @(posedge hclk) hresetn <= 1'b1;
        wait_bit(3, 2000);
        @(posedge hclk) ldo_dip <= 1'b1;
        tick(4300);
        chk_pin("ldo_enable uv", 1'b0, ldo_enable);
        bus(1'b0, `LBRS_IRQ_STAT_OFS, 32'h1, 32'h5);
        $display("test undervoltage done");
        finish_test();
    end
endmodule // test_lcd_bias_rail_sequencer
